// file: rtl/pwm_group_control_regs.svh
// Register offsets, field positions and reset values of the PWM group block
`ifndef PWM_GROUP_CONTROL_REGS_SVH
`define PWM_GROUP_CONTROL_REGS_SVH

`define PWM_CH_COUNT 6
`define PWM_ADDR_W 8
`define PWM_CNT_W 16
`define PWM_DIV_W 3
`define PWM_PRE_W 7

`define GLB_OFS 8'h00
`define CH0_CTL0_OFS 8'h04
`define CH0_CTL1_OFS 8'h08
`define CH_STRIDE 8'h0c
`define STATUS_OFS 8'h80

`define GLB_EN_ALL 0
`define GLB_LD_ALL 4
`define GLB_EN_012 8
`define GLB_EN_345 10
`define GLB_EN_PAIR 12
`define GLB_WMASK 32'h0003ff11
`define GLB_RST 32'h00000000

`define CTL0_INSTANT 31
`define CTL0_LOAD 16
`define CTL0_DIV_LSB 12
`define CTL0_MODE 8
`define CTL0_POL 4
`define CTL0_EN 0
`define CTL0_WMASK 32'h80017111
`define CTL0_RST 32'h00000000

`define CTL1_CMP_LSB 16
`define CTL1_TOP_LSB 0
`define CTL1_RST 32'h00000000

`define STAT_RUN_LSB 8
`define STAT_DOWN_LSB 16

`endif

// file: rtl/pwm_group_control_pkg.sv
// Types shared by the PWM group block
package pwm_group_control_pkg;

	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} dir_t;

	typedef struct packed {
		logic [2:0] div;
		logic mode;
		logic pol;
		logic [15:0] cmp;
		logic [15:0] top;
		logic [15:0] cnt;
		dir_t dir;
		logic out;
	} chan_state_t;

	typedef struct packed {
		logic [6:0] cnt;
	} prescale_state_t;

endpackage

// file: rtl/pwm_prescaler.sv
// Power-of-two count clock enable for one PWM channel
`timescale 1ns/100ps
`include "pwm_group_control_regs.svh"

module pwm_prescaler #(
	parameter int DIV_W = `PWM_DIV_W,
	parameter int PRE_W = `PWM_PRE_W
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_run,
	input wire logic [DIV_W-1:0] i_div,
	output logic o_tick
);

	pwm_group_control_pkg::prescale_state_t st_reg;
	pwm_group_control_pkg::prescale_state_t st_next;
	logic [PRE_W-1:0] mask;

	// Divide by two to the power of i_div
	assign mask = PRE_W'(({{PRE_W{1'b0}}, 1'b1} << i_div) - 1'b1);
	assign o_tick = i_run && ((st_reg.cnt & mask) == mask);

	always_comb begin
		st_next = st_reg;
		if (!i_run) begin
			st_next.cnt = '0;
		end else begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_reg <= '0;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

endmodule

// file: rtl/pwm_group_control.sv
// Six-channel PWM with group enable and load control
//
// Summary of operation
// - Group enables act only together with each channel's own enable bit 0.
// - Group loads act only together with each channel's own load bit 16.
// - Global bit 16 enables channels 4,5; bit 17 loads them.
// - Global bit 14 enables channels 2,3; bit 15 loads them.
// - Global bit 12 enables channels 0,1; bit 13 loads them.
// - Global bit 10 enables channels 3,4,5; bit 11 loads them.
// - Global bit 8 enables channels 0,1,2; bit 9 loads them.
// - Global bit 0 enables all six channels; bit 4 loads all.
// - Global unused bits read zero, writable bits reset to zero.
// - Channel control bit 31 applies new parameters at once.
// - Channel control bit 16 requests a parameter load.
// - Prescaler bits 14:12 divide the clock by two to that power.
// - Mode bit 8 selects up counting or up-down counting.
// - Polarity bit 4 makes the second edge rising or falling.
// - Second control register holds compare 31:16 and top 15:0.
// - Channel control bit 0 enables that channel.
// - In up mode the counter runs zero to top, then zero.
// - Output toggles at the compare threshold.
`timescale 1ns/100ps
`include "pwm_group_control_regs.svh"

module pwm_group_control #(
	parameter int NUM_CH = `PWM_CH_COUNT,
	parameter int ADDR_W = `PWM_ADDR_W,
	parameter int CNT_W = `PWM_CNT_W
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic [NUM_CH-1:0] o_pwm
);

	typedef struct packed {
		logic [31:0] glb;
		logic [NUM_CH-1:0][31:0] ctl0;
		logic [NUM_CH-1:0][31:0] ctl1;
		pwm_group_control_pkg::chan_state_t [NUM_CH-1:0] ch;
		logic [NUM_CH-1:0] run;
		logic [31:0] rdata;
	} top_state_t;

	top_state_t st_reg;
	top_state_t st_next;
	logic [NUM_CH-1:0] tick;

	// Address of a channel's first control register
	function automatic logic [ADDR_W-1:0] ctl0_addr(input int ch);
		ctl0_addr = ADDR_W'(`CH0_CTL0_OFS + `CH_STRIDE * ch);
	endfunction

	// Address of a channel's second control register
	function automatic logic [ADDR_W-1:0] ctl1_addr(input int ch);
		ctl1_addr = ADDR_W'(`CH0_CTL1_OFS + `CH_STRIDE * ch);
	endfunction

	// Whether any group bit covering a channel is set
	function automatic logic grp_hit(
		input logic [31:0] glb,
		input int ch,
		input logic is_load
	);
		int off;
		logic all_bit;
		logic tri_bit;
		logic pair_bit;
		// Load bits sit one above their enables, except for all six
		off = is_load ? 1 : 0;
		if (is_load) begin
			all_bit = glb[`GLB_LD_ALL];
		end else begin
			all_bit = glb[`GLB_EN_ALL];
		end
		unique case (ch)
			0, 1: begin
				tri_bit = glb[`GLB_EN_012 + off];
				pair_bit = glb[`GLB_EN_PAIR + off];
			end
			2: begin
				tri_bit = glb[`GLB_EN_012 + off];
				pair_bit = glb[`GLB_EN_PAIR + 2 + off];
			end
			3: begin
				tri_bit = glb[`GLB_EN_345 + off];
				pair_bit = glb[`GLB_EN_PAIR + 2 + off];
			end
			4, 5: begin
				tri_bit = glb[`GLB_EN_345 + off];
				pair_bit = glb[`GLB_EN_PAIR + 4 + off];
			end
			default: begin
				tri_bit = 1'b0;
				pair_bit = 1'b0;
			end
		endcase
		grp_hit = all_bit | tri_bit | pair_bit;
	endfunction

	// Register selects; is_glb serves the write and read paths, is_status only the read path
	function automatic logic is_glb(input logic [ADDR_W-1:0] a);
		is_glb = (a == ADDR_W'(`GLB_OFS));
	endfunction

	function automatic logic is_status(input logic [ADDR_W-1:0] a);
		is_status = (a == ADDR_W'(`STATUS_OFS));
	endfunction

	// A channel runs when its own bit and a covering group bit are set
	function automatic logic chan_run(
		input logic [31:0] glb,
		input logic [31:0] c0,
		input int ch
	);
		chan_run = c0[`CTL0_EN] && grp_hit(glb, ch, 1'b0);
	endfunction

	// Status word: output levels, running and counting-down flags
	function automatic logic [31:0] status_word(input top_state_t s);
		logic [31:0] w;
		w = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			w[c] = s.ch[c].out;
			w[`STAT_RUN_LSB + c] = s.run[c];
			w[`STAT_DOWN_LSB + c] =
				(s.ch[c].dir == pwm_group_control_pkg::DIR_DOWN);
		end
		status_word = w;
	endfunction

	// Read data for one address; unmapped addresses read zero
	function automatic logic [31:0] read_mux(
		input top_state_t s,
		input logic [ADDR_W-1:0] a
	);
		logic [31:0] w;
		w = '0;
		if (is_glb(a)) begin
			w = s.glb;
		end
		if (is_status(a)) begin
			w = status_word(s);
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (a == ctl0_addr(c)) begin
				w = s.ctl0[c];
			end
			if (a == ctl1_addr(c)) begin
				w = s.ctl1[c];
			end
		end
		read_mux = w;
	endfunction

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		pwm_group_control_pkg::dir_t dir;
		logic bnd;
	} step_t;

	// One count step; bnd marks a period boundary
	function automatic step_t count_step(
		input pwm_group_control_pkg::chan_state_t s
	);
		step_t r;
		r.cnt = s.cnt;
		r.dir = s.dir;
		r.bnd = 1'b0;
		unique case (s.dir)
			pwm_group_control_pkg::DIR_UP: begin
				if (r.cnt >= s.top) begin
					if (s.mode && s.top != '0) begin
						r.dir = pwm_group_control_pkg::DIR_DOWN;
						r.cnt = s.top - 1'b1;
					end else begin
						r.cnt = '0;
						r.bnd = 1'b1;
					end
				end else begin
					r.cnt = r.cnt + 1'b1;
				end
			end
			pwm_group_control_pkg::DIR_DOWN: begin
				if (r.cnt == '0) begin
					r.dir = pwm_group_control_pkg::DIR_UP;
					r.cnt = (s.top != '0) ? CNT_W'(1) : '0;
					r.bnd = 1'b1;
				end else begin
					r.cnt = r.cnt - 1'b1;
				end
			end
			default: begin
				r.dir = pwm_group_control_pkg::DIR_UP;
				r.cnt = '0;
			end
		endcase
		count_step = r;
	endfunction

	// Active settings taken from the two control words
	function automatic pwm_group_control_pkg::chan_state_t take_shadow(
		input pwm_group_control_pkg::chan_state_t s,
		input logic [31:0] c0,
		input logic [31:0] c1
	);
		pwm_group_control_pkg::chan_state_t r;
		r = s;
		r.div = c0[`CTL0_DIV_LSB +: `PWM_DIV_W];
		r.mode = c0[`CTL0_MODE];
		r.pol = c0[`CTL0_POL];
		r.cmp = c1[`CTL1_CMP_LSB +: `PWM_CNT_W];
		r.top = c1[`CTL1_TOP_LSB +: `PWM_CNT_W];
		take_shadow = r;
	endfunction

	always_comb begin
		logic run;
		logic ld;
		logic inst;
		logic bnd;
		logic [CNT_W-1:0] cnt;
		step_t stp;
		pwm_group_control_pkg::dir_t dir;
		logic [31:0] sh0;
		logic [31:0] sh1;
		run = 1'b0;
		ld = 1'b0;
		inst = 1'b0;
		bnd = 1'b0;
		cnt = '0;
		stp = '0;
		dir = pwm_group_control_pkg::DIR_UP;
		sh0 = '0;
		sh1 = '0;
		st_next = st_reg;
		st_next.rdata = '0;

		// Register writes; read-only bits stay zero
		if (i_wr && is_glb(i_addr)) begin
			st_next.glb = i_wdata & `GLB_WMASK;
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (i_wr && i_addr == ctl0_addr(c)) begin
				st_next.ctl0[c] = i_wdata & `CTL0_WMASK;
			end
			if (i_wr && i_addr == ctl1_addr(c)) begin
				st_next.ctl1[c] = i_wdata;
			end
		end

		// Register reads, answered in the next cycle
		if (i_rd) begin
			st_next.rdata = read_mux(st_reg, i_addr);
		end

		// Channel counters
		for (int c = 0; c < NUM_CH; c++) begin
			sh0 = st_reg.ctl0[c];
			sh1 = st_reg.ctl1[c];
			run = chan_run(st_reg.glb, sh0, c);
			ld = sh0[`CTL0_LOAD] && grp_hit(st_reg.glb, c, 1'b1);
			inst = sh0[`CTL0_INSTANT];
			bnd = 1'b0;
			cnt = st_reg.ch[c].cnt;
			dir = st_reg.ch[c].dir;
			st_next.run[c] = run;

			if (!run) begin
				cnt = '0;
				dir = pwm_group_control_pkg::DIR_UP;
				st_next.ch[c].out = 1'b0;
			end else if (tick[c]) begin
				stp = count_step(st_reg.ch[c]);
				cnt = stp.cnt;
				dir = stp.dir;
				bnd = stp.bnd;
			end

			st_next.ch[c].cnt = cnt;
			st_next.ch[c].dir = dir;
			if (run) begin
				// High below threshold, then low; inverted by polarity
				st_next.ch[c].out =
					(cnt < st_reg.ch[c].cmp) ^ st_reg.ch[c].pol;
			end

			// Active settings follow the shadow copy
			// Normal loads wait for a boundary so no period is cut
			if (!run || inst || (ld && bnd)) begin
				st_next.ch[c] = take_shadow(st_next.ch[c], sh0, sh1);
			end
			if (ld && bnd) begin
				st_next.ch[c].cnt = cnt;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_reg <= '0;
			st_reg.glb <= `GLB_RST;
			for (int c = 0; c < NUM_CH; c++) begin
				st_reg.ctl0[c] <= `CTL0_RST;
				st_reg.ctl1[c] <= `CTL1_RST;
				st_reg.ch[c].dir <= pwm_group_control_pkg::DIR_UP;
			end
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	assign o_rdata = st_reg.rdata;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			pwm_prescaler #(
				.DIV_W(`PWM_DIV_W),
				.PRE_W(`PWM_PRE_W)
			) u_pre (
				.i_core_clk(i_core_clk),
				.i_rst_b(i_rst_b),
				.i_ce(i_ce),
				.i_run(st_reg.run[g]),
				.i_div(st_reg.ch[g].div),
				.o_tick(tick[g])
			);
			assign o_pwm[g] = st_reg.ch[g].out;
		end
	endgenerate

endmodule

// file: verif/pwm_group_control_asserts.sv
// Port-level checks for the PWM group block
`timescale 1ns/100ps
module pwm_group_control_chk #(
	parameter int NUM_CH = 6,
	parameter int ADDR_W = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [NUM_CH-1:0] o_pwm
);
	logic [31:0] g_reg, c0_reg, c1_reg;
	logic [5:0] ge, h1_reg, h2_reg, h3_reg, any_g;
	logic wok;
	// Group gate per channel, ch0 also with its own enable
	always_comb begin
		ge[1] = g_reg[0] | g_reg[8] | g_reg[12];
		ge[0] = c0_reg[0] & ge[1];
		ge[2] = g_reg[0] | g_reg[8] | g_reg[14];
		ge[3] = g_reg[0] | g_reg[10] | g_reg[14];
		ge[4] = g_reg[0] | g_reg[10] | g_reg[16];
		ge[5] = ge[4];
		any_g = ge | h1_reg | h2_reg | h3_reg;
		wok = i_ce & i_wr;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			g_reg <= '0;
			c0_reg <= '0;
			c1_reg <= '0;
			h1_reg <= '0;
			h2_reg <= '0;
			h3_reg <= '0;
		end else begin
			if (wok && i_addr == 8'h00) g_reg <= i_wdata & 32'h0003ff11;
			if (wok && i_addr == 8'h04) c0_reg <= i_wdata & 32'h80017111;
			if (wok && i_addr == 8'h08) c1_reg <= i_wdata;
			h1_reg <= ge;
			h2_reg <= h1_reg;
			h3_reg <= h2_reg;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	chk_glb_read: assert property (i_rd && i_ce && i_addr == 8'h00 |=>
		o_rdata == $past(g_reg)) else $error("group register readback");
	chk_ctl0_read: assert property (i_rd && i_ce && i_addr == 8'h04 |=>
		o_rdata == $past(c0_reg)) else $error("ch0 control readback");
	chk_ctl1_read: assert property (i_rd && i_ce && i_addr == 8'h08 |=>
		o_rdata == $past(c1_reg)) else $error("ch0 limits readback");
	chk_gate_ch0: assert property (!any_g[0] |-> !o_pwm[0])
		else $error("ch0 output while gated off");
	chk_gate_01: assert property (!any_g[1] |-> !o_pwm[1])
		else $error("ch1 output while gated off");
	chk_gate_23: assert property ((o_pwm[3:2] & ~any_g[3:2]) == 2'h0)
		else $error("ch2/3 output while gated off");
	chk_gate_45: assert property ((o_pwm[5:4] & ~any_g[5:4]) == 2'h0)
		else $error("ch4/5 output while gated off");
	chk_rise_run: assert property ($rose(o_pwm[0]) |-> $past(any_g[0]))
		else $error("ch0 rose without enables");
endmodule
bind pwm_group_control pwm_group_control_chk #(.NUM_CH(NUM_CH),
	.ADDR_W(ADDR_W)) pwm_group_control_chk_i (.i_core_clk(i_core_clk),
	.i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pwm(o_pwm));

// file: verif/pwm_group_control_tb_top.sv
// Self-checking bench for the PWM group block
`timescale 1ns/100ps
module pwm_group_control_tb_top;
	logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, ce = 1'h1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [5:0] pwm;
	int err_count = 0, tests_run = 0;
	always #5 clk = ~clk;
	pwm_group_control pwm_group_control_i (.i_core_clk(clk), .i_rst_b(rst_b),
		.i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_pwm(pwm));
	task automatic conclude;
		$display("errors %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(rdata, e);
	endtask
	// Rising edges and high cycles of one channel over 192 cycles
	task automatic meas(input int ch, output int r, output int h);
		logic p;
		r = 0;
		h = 0;
		@(posedge clk);
		#1 p = pwm[ch];
		repeat (192) begin
			@(posedge clk);
			#1 h += (pwm[ch] === 1'h1);
			r += (pwm[ch] === 1'h1 && p === 1'h0);
			p = pwm[ch];
		end
	endtask
	// Program ch0 while stopped (cmp 1, top 3), then start it
	task automatic run(input logic [31:0] g, c, input int er, eh);
		int r, h;
		wr_reg(8'h00, 32'h00000000);
		wr_reg(8'h04, c);
		wr_reg(8'h08, 32'h00010003);
		wr_reg(8'h00, g);
		repeat (20) @(posedge clk);
		meas(0, r, h);
		chk(r, er);
		chk(h, eh);
	endtask
	// Change settings while running
	task automatic upd(input logic [31:0] g, c, d, input int e);
		int r, h;
		wr_reg(8'h08, d);
		wr_reg(8'h04, c);
		wr_reg(8'h00, g);
		repeat (20) @(posedge clk);
		meas(0, r, h);
		chk(r, e);
		chk(h, e);
	endtask
	initial begin
		int r4, h4;
		logic [5:0] p6;
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		rd_reg(8'h00, 32'h00000000);
		rd_reg(8'h04, 32'h00000000);
		wr_reg(8'h00, 32'hffffffff);
		rd_reg(8'h00, 32'h0003ff11);
		wr_reg(8'h04, 32'hffffffff);
		rd_reg(8'h04, 32'h80017111);
		wr_reg(8'h08, 32'h12345678);
		rd_reg(8'h08, 32'h12345678);
		wr_reg(8'h7c, 32'hffffffff);
		rd_reg(8'h7c, 32'h00000000);
		run(32'h00000001, 32'h00000001, 48, 48);
		run(32'h00000100, 32'h00001001, 24, 48);
		run(32'h00001000, 32'h00002001, 12, 48);
		run(32'h00000001, 32'h00003001, 6, 48);
		run(32'h00000001, 32'h00004001, 3, 48);
		run(32'h00000001, 32'h00000101, 32, 32);
		run(32'h00000001, 32'h00000011, 48, 144);
		run(32'h00014400, 32'h00000001, 0, 0);
		run(32'h00000001, 32'h00000000, 0, 0);
		run(32'h00000001, 32'h00000001, 48, 48);
		upd(32'h00000001, 32'h00000001, 32'h00010007, 48);
		upd(32'h00028801, 32'h00010001, 32'h00010007, 48);
		upd(32'h00002011, 32'h00000001, 32'h00010007, 48);
		upd(32'h00000011, 32'h00010001, 32'h00010007, 24);
		run(32'h00000001, 32'h00000001, 48, 48);
		upd(32'h00000001, 32'h80000001, 32'h00010007, 24);
		// Channel 4 through its pair bit; ch0 is not covered
		wr_reg(8'h00, 32'h00000000);
		wr_reg(8'h34, 32'h00000001);
		wr_reg(8'h38, 32'h00010003);
		wr_reg(8'h00, 32'h00010000);
		repeat (20) @(posedge clk);
		meas(4, r4, h4);
		chk(r4, 48);
		chk(h4, 48);
		chk(pwm[0], 1'h0);
		// Clock enable low freezes the outputs
		@(posedge clk);
		ce <= 1'h0;
		@(posedge clk);
		#1 p6 = pwm;
		repeat (8) @(posedge clk);
		#1 chk(pwm, p6);
		@(posedge clk);
		ce <= 1'h1;
		conclude();
	end
endmodule
